/* File: hw/dsss_tx_serializer.sv */
// transmit byte serializer with spreading-sequence and status registers
// assumes a byte register port already decoded from the host serial link
`timescale 1ns/10ps
// Overview of operation
// [R1] status flags set regardless of interrupt enables
// [R2] transmit status reads zero unless transmit is enabled
// [R3] status register ignores host writes
// [R4] data byte shifted out bit zero first
// [R5] mask bit qualifies same data bit
// [R6] sequence register spreads every transmitted bit
// [R7] full mode uses all 64 chips
// [R8] two independent 32-chip halves selectable
// [R9] chips emitted from bit 0 upward
// [R10] sequence bytes at 0x11 through 0x18
// [R11] host programs only well-correlating sequences
// [R12] empty sets on load, byte write clears; a byte write in the load cycle leaves empty set
// [R13] overflow on early write, status read clears
// [R14] underflow after a bit, status read clears
// [R15] send while valid bits remain in shifter
// [R16] reset restores data, mask and sequence
module dsss_tx_serializer
    import dsss_tx_pkg::*;
#(
    parameter int ADDR_W = REG_ADDR_W
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic tx_chip,
    output logic tx_chip_strobe,
    output logic tx_chip_data,
    output logic tx_busy
);
    if (ADDR_W != REG_ADDR_W) begin : g_addr_check
        $error("register address width must be six bits");
    end

    typedef struct packed {
        logic [7:0] control;
        spread_mode_t mode;
        logic [7:0] tx_byte;
        logic [7:0] tx_mask;
        logic [63:0] seq;
        logic pending;
        logic [7:0] shift_data;
        logic [7:0] shift_mask;
        logic in_flight;
        logic sent_any;
        logic [3:0] flags;
        logic [7:0] rdata;
    } top_state_t;

    top_state_t s;
    top_state_t next_s;
    spread_if link ();

    logic tx_en;
    logic wr_byte;
    logic rd_status;
    logic load;
    logic start_bit;
    logic drained;
    logic [2:0] seq_sel;
    logic [ADDR_W-1:0] seq_off;
    logic seq_hit;

    chip_spreader u_spreader (
        .clk(clk),
        .rst(rst),
        .link(link.spreader),
        .chip(tx_chip),
        .chip_strobe(tx_chip_strobe),
        .chip_data(tx_chip_data)
    );

    assign tx_en = s.control[CTRL_TX_EN_BIT];
    assign wr_byte = reg_wr && reg_addr == ADDR_TX_BYTE;
    assign rd_status = reg_rd && reg_addr == ADDR_TX_STATUS;
    assign seq_hit = reg_addr >= ADDR_SEQ_LO && reg_addr <= ADDR_SEQ_HI;
    assign seq_off = reg_addr - ADDR_SEQ_LO;
    assign seq_sel = seq_off[2:0];
    // a new byte enters only once every valid bit has left [R15]
    assign load = tx_en && !s.in_flight && s.shift_mask == 8'h00 && s.pending;
    assign start_bit = tx_en && !s.in_flight && s.shift_mask != 8'h00 && link.ready;
    assign drained = link.symbol_done && s.shift_mask == 8'h00 && !s.pending;

    assign link.start = start_bit;
    assign link.data_bit = s.shift_data[0]; // [R4]
    assign link.data_valid = s.shift_mask[0]; // [R5]
    assign link.sequence_code = s.seq; // [R6]
    assign link.mode = s.mode;
    assign reg_rdata = s.rdata;
    assign tx_busy = s.in_flight || s.shift_mask != 8'h00;

    always_comb begin
        next_s = s;
        // register writes; the status register has no write path [R3]
        if (reg_wr) begin
            case (reg_addr)
                ADDR_CONTROL: next_s.control = reg_wdata;
                ADDR_TX_BYTE: next_s.tx_byte = reg_wdata;
                ADDR_TX_MASK: next_s.tx_mask = reg_wdata;
                ADDR_SPREAD_MODE: next_s.mode = spread_mode_t'(reg_wdata[1:0]);
                default: begin
                    if (seq_hit) begin
                        next_s.seq[{seq_sel, 3'h0} +: 8] = reg_wdata; // [R10]
                    end
                end
            endcase
        end

        // reading the status clears all but empty [R13] [R14]
        if (rd_status) begin
            next_s.flags[ST_DONE] = 1'b0;
            next_s.flags[ST_OVERFLOW] = 1'b0;
            next_s.flags[ST_UNDERFLOW] = 1'b0;
        end
        if (wr_byte) begin
            next_s.flags[ST_EMPTY] = 1'b0; // [R12]
        end

        // byte hand-off into the shifter
        if (load) begin
            next_s.shift_data = s.tx_byte;
            next_s.shift_mask = s.tx_mask;
            next_s.pending = wr_byte;
            next_s.flags[ST_EMPTY] = 1'b1; // [R12] [R1]
        end else if (wr_byte) begin
            next_s.pending = 1'b1;
            if (s.pending) begin
                next_s.flags[ST_OVERFLOW] = 1'b1; // [R13] [R1]
            end
        end

        // one bit per symbol, least significant first [R4] [R15]
        if (start_bit) begin
            next_s.shift_data = {1'b0, s.shift_data[7:1]};
            next_s.shift_mask = {1'b0, s.shift_mask[7:1]};
            next_s.in_flight = 1'b1;
            next_s.sent_any = 1'b1;
        end
        if (link.symbol_done) begin
            next_s.in_flight = 1'b0;
        end
        if (drained && s.sent_any) begin
            next_s.flags[ST_DONE] = 1'b1;
            next_s.flags[ST_UNDERFLOW] = 1'b1; // [R14] [R1]
        end

        // read data, one cycle after the strobe
        if (reg_rd) begin
            case (reg_addr)
                ADDR_CONTROL: next_s.rdata = s.control;
                ADDR_TX_STATUS: next_s.rdata = tx_en ? {4'h0, s.flags} : 8'h00; // [R2]
                ADDR_TX_BYTE: next_s.rdata = s.tx_byte;
                ADDR_TX_MASK: next_s.rdata = s.tx_mask;
                ADDR_SPREAD_MODE: next_s.rdata = {6'h00, s.mode};
                default: next_s.rdata = seq_hit ? s.seq[{seq_sel, 3'h0} +: 8] : 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{control: CONTROL_RESET, mode: MODE_FULL, tx_byte: TX_BYTE_RESET,
                   tx_mask: TX_MASK_RESET, seq: SEQ_RESET, flags: STATUS_RESET,
                   default: '0}; // [R16]
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_status_gated;
        rd_status && !tx_en |=> reg_rdata == 8'h00;
    endproperty
    a_status_gated: assert property (p_status_gated) else $error("status not gated"); // [R2]

    property p_status_polled;
        rd_status && tx_en |=> reg_rdata == {4'h0, $past(s.flags)};
    endproperty
    a_status_polled: assert property (p_status_polled) else $error("flags not readable"); // [R1]

    property p_status_ro;
        reg_wr && reg_addr == ADDR_TX_STATUS && !rd_status && !load && !wr_byte
            && !link.symbol_done |=> s.flags == $past(s.flags);
    endproperty
    a_status_ro: assert property (p_status_ro) else $error("status changed by write"); // [R3]

    property p_lsb_first;
        start_bit |-> link.data_bit == s.shift_data[0]
            ##1 s.shift_data == {1'b0, $past(s.shift_data[7:1])};
    endproperty
    a_lsb_first: assert property (p_lsb_first) else $error("bit order wrong"); // [R4]

    property p_mask_qualifies;
        load |=> s.shift_mask == $past(s.tx_mask) ##0 link.data_valid == s.shift_mask[0];
    endproperty
    a_mask_qualifies: assert property (p_mask_qualifies) else $error("mask not applied"); // [R5]

    property p_seq_write;
        reg_wr && reg_addr == ADDR_SEQ_HI |=> s.seq[63:56] == $past(reg_wdata);
    endproperty
    a_seq_write: assert property (p_seq_write) else $error("sequence byte map wrong"); // [R10]

    property p_empty_set;
        load |=> s.flags[ST_EMPTY];
    endproperty
    a_empty_set: assert property (p_empty_set) else $error("empty not set"); // [R12]

    property p_empty_clear;
        wr_byte && !load |=> !s.flags[ST_EMPTY];
    endproperty
    a_empty_clear: assert property (p_empty_clear) else $error("empty not cleared"); // [R12]

    property p_overflow;
        wr_byte && s.pending && !load |=> s.flags[ST_OVERFLOW];
    endproperty
    a_overflow: assert property (p_overflow) else $error("overflow missed"); // [R13]

    property p_read_clear;
        rd_status && !(wr_byte && s.pending && !load) |=> !s.flags[ST_OVERFLOW];
    endproperty
    a_read_clear: assert property (p_read_clear) else $error("overflow not cleared"); // [R13]

    property p_underflow;
        drained && s.sent_any |=> s.flags[ST_UNDERFLOW];
    endproperty
    a_underflow: assert property (p_underflow) else $error("underflow missed"); // [R14]

    property p_stop;
        s.shift_mask == 8'h00 |-> !start_bit;
    endproperty
    a_stop: assert property (p_stop) else $error("sent without valid bits"); // [R15]

    property p_reset_values;
        disable iff (1'b0) rst |=> s.tx_byte == TX_BYTE_RESET && s.tx_mask == TX_MASK_RESET
            && s.seq == SEQ_RESET;
    endproperty
    a_reset_values: assert property (p_reset_values) else $error("reset values wrong"); // [R16]

    property p_control_write;
        reg_wr && reg_addr == ADDR_CONTROL |=> s.control == $past(reg_wdata);
    endproperty
    a_control_write: assert property (p_control_write) else $error("control lost"); // [R2]

    property p_status_reserved;
        rd_status |=> reg_rdata[7:4] == 4'h0;
    endproperty
    a_status_reserved: assert property (p_status_reserved) else $error("reserved set"); // [R1]

    property p_byte_write;
        wr_byte |=> s.tx_byte == $past(reg_wdata) && s.pending;
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("byte not pending"); // [R13]

    property p_mask_write;
        reg_wr && reg_addr == ADDR_TX_MASK |=> s.tx_mask == $past(reg_wdata);
    endproperty
    a_mask_write: assert property (p_mask_write) else $error("mask not written"); // [R5]

    property p_seq_lo_write;
        reg_wr && reg_addr == ADDR_SEQ_LO |=> s.seq[7:0] == $past(reg_wdata);
    endproperty
    a_seq_lo_write: assert property (p_seq_lo_write) else $error("low byte wrong"); // [R10]

    property p_seq_read;
        reg_rd && reg_addr == ADDR_SEQ_HI |=> reg_rdata == $past(s.seq[63:56]);
    endproperty
    a_seq_read: assert property (p_seq_read) else $error("sequence read wrong"); // [R10]

    property p_empty_hold;
        !wr_byte && !load |=> s.flags[ST_EMPTY] == $past(s.flags[ST_EMPTY]);
    endproperty
    a_empty_hold: assert property (p_empty_hold) else $error("empty changed"); // [R12]

    property p_overflow_hold;
        s.flags[ST_OVERFLOW] && !rd_status |=> s.flags[ST_OVERFLOW];
    endproperty
    a_overflow_hold: assert property (p_overflow_hold) else $error("overflow lost"); // [R13]

    property p_done_set;
        drained && s.sent_any |=> s.flags[ST_DONE];
    endproperty
    a_done_set: assert property (p_done_set) else $error("done missed"); // [R14]

    property p_underflow_clear;
        rd_status && !(drained && s.sent_any) |=> !s.flags[ST_UNDERFLOW];
    endproperty
    a_underflow_clear: assert property (p_underflow_clear) else $error("underflow kept"); // [R14]

    property p_shift_drains;
        start_bit |=> s.shift_mask == {1'b0, $past(s.shift_mask[7:1])};
    endproperty
    a_shift_drains: assert property (p_shift_drains) else $error("mask not shifted"); // [R15]

    c_overflow: cover property (wr_byte && s.pending && !load);
    c_underflow: cover property (drained && s.sent_any);
    c_half_byte: cover property (load && s.tx_mask == 8'h0F);
endmodule

/* File: hw/dsss_tx_pkg.sv */
// constants, field layouts and types of the transmit serializer and spreader
// assumes a byte-wide register port decoded from the host serial link
package dsss_tx_pkg;
    localparam int REG_ADDR_W = 6;
    localparam logic [REG_ADDR_W-1:0] ADDR_CONTROL = 6'h03;
    localparam logic [REG_ADDR_W-1:0] ADDR_TX_STATUS = 6'h0E;
    localparam logic [REG_ADDR_W-1:0] ADDR_TX_BYTE = 6'h0F;
    localparam logic [REG_ADDR_W-1:0] ADDR_TX_MASK = 6'h10;
    localparam logic [REG_ADDR_W-1:0] ADDR_SEQ_LO = 6'h11;
    localparam logic [REG_ADDR_W-1:0] ADDR_SEQ_HI = 6'h18;
    localparam logic [REG_ADDR_W-1:0] ADDR_SPREAD_MODE = 6'h1F;

    localparam int CTRL_TX_EN_BIT = 7;
    localparam int CTRL_RX_EN_BIT = 6;
    localparam int ST_EMPTY = 0;
    localparam int ST_DONE = 1;
    localparam int ST_OVERFLOW = 2;
    localparam int ST_UNDERFLOW = 3;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] TX_BYTE_RESET = 8'h00;
    localparam logic [7:0] TX_MASK_RESET = 8'h00;
    localparam logic [3:0] STATUS_RESET = 4'h0;
    localparam logic [63:0] SEQ_RESET = 64'h1e8b_6a3d_e0e9_b222;

    localparam logic [5:0] CHIP_FIRST_LO = 6'h00;
    localparam logic [5:0] CHIP_LAST_LO = 6'h1F;
    localparam logic [5:0] CHIP_FIRST_HI = 6'h20;
    localparam logic [5:0] CHIP_LAST_HI = 6'h3F;

    typedef enum logic [1:0] {
        MODE_FULL = 2'h0,
        MODE_LOW = 2'h1,
        MODE_HIGH = 2'h2,
        MODE_BOTH = 2'h3
    } spread_mode_t;

    typedef enum logic [1:0] {
        SP_IDLE = 2'b01,
        SP_RUN = 2'b10
    } spread_fsm_t;
endpackage

/* File: hw/spread_if.sv */
// handshake between the bit serializer and the chip spreader
// assumes both ends share one clock
`timescale 1ns/10ps
interface spread_if;
    import dsss_tx_pkg::*;
    logic start;
    logic data_bit;
    logic data_valid;
    logic ready;
    logic symbol_done;
    logic [63:0] sequence_code;
    spread_mode_t mode;

    modport serializer (
        output start, data_bit, data_valid, sequence_code, mode,
        input ready, symbol_done
    );
    modport spreader (
        input start, data_bit, data_valid, sequence_code, mode,
        output ready, symbol_done
    );
endinterface

/* File: hw/chip_spreader.sv */
// spreads one data bit into 64 or 32 chips of the programmed sequence
// assumes start is offered only while ready is high
`timescale 1ns/10ps
module chip_spreader
    import dsss_tx_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    spread_if.spreader link,
    output logic chip,
    output logic chip_strobe,
    output logic chip_data
);
    typedef struct packed {
        spread_fsm_t st;
        logic [5:0] idx;
        logic [5:0] last;
        logic bit_val;
        logic bit_ok;
        logic alt;
        logic chip;
        logic strobe;
        logic data;
        logic done;
    } spread_state_t;

    spread_state_t s;
    spread_state_t next_s;

    assign link.ready = (s.st == SP_IDLE);
    assign link.symbol_done = s.done;
    assign chip = s.chip;
    assign chip_strobe = s.strobe;
    assign chip_data = s.data;

    always_comb begin
        next_s = s;
        next_s.strobe = 1'b0;
        next_s.done = 1'b0;
        case (s.st)
            SP_IDLE: begin
                if (link.start) begin
                    next_s.st = SP_RUN;
                    next_s.bit_val = link.data_bit;
                    next_s.bit_ok = link.data_valid;
                    case (link.mode)
                        MODE_FULL: begin // [R7]
                            next_s.idx = CHIP_FIRST_LO;
                            next_s.last = CHIP_LAST_HI;
                        end
                        MODE_LOW: begin // [R8]
                            next_s.idx = CHIP_FIRST_LO;
                            next_s.last = CHIP_LAST_LO;
                        end
                        MODE_HIGH: begin // [R8]
                            next_s.idx = CHIP_FIRST_HI;
                            next_s.last = CHIP_LAST_HI;
                        end
                        default: begin // halves alternate bit by bit [R8]
                            next_s.idx = s.alt ? CHIP_FIRST_HI : CHIP_FIRST_LO;
                            next_s.last = s.alt ? CHIP_LAST_HI : CHIP_LAST_LO;
                            next_s.alt = ~s.alt;
                        end
                    endcase
                end
            end
            SP_RUN: begin
                // a one sends the sequence, a zero its inverse [R6] [R9]
                next_s.chip = link.sequence_code[s.idx] ~^ s.bit_val;
                next_s.data = s.bit_ok;
                next_s.strobe = 1'b1;
                next_s.idx = s.idx + 6'h01;
                if (s.idx == s.last) begin
                    next_s.st = SP_IDLE;
                    next_s.done = 1'b1;
                end
            end
            default: next_s.st = SP_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s <= '{st: SP_IDLE, default: '0};
        end else begin
            s <= next_s;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_full_length;
        link.start && link.ready && link.mode == MODE_FULL |-> ##65 s.done;
    endproperty
    a_full_length: assert property (p_full_length) else $error("full code not 64 chips"); // [R7]

    property p_half_length;
        link.start && link.ready && link.mode != MODE_FULL |-> ##33 s.done;
    endproperty
    a_half_length: assert property (p_half_length) else $error("half code not 32 chips"); // [R8]

    property p_chip_order;
        s.st == SP_RUN |=> s.chip == ($past(link.sequence_code[s.idx]) ~^ $past(s.bit_val));
    endproperty
    a_chip_order: assert property (p_chip_order) else $error("chip out of order"); // [R9]

    property p_first_chip;
        link.start && link.ready && (link.mode == MODE_FULL || link.mode == MODE_LOW
            || (link.mode == MODE_BOTH && !s.alt))
            |-> ##2 (s.strobe
            && s.chip == ($past(link.sequence_code[0], 2) ~^ $past(link.data_bit, 2)));
    endproperty
    a_first_chip: assert property (p_first_chip) else $error("first chip not bit 0"); // [R9]

    c_full_symbol: cover property (s.done && s.last == CHIP_LAST_HI && s.idx == 6'h00);
    c_half_symbol: cover property (s.done && s.last == CHIP_LAST_LO);
endmodule

/* File: verif/chip_sink.sv */
// receiving end of the chip stream: logs every chip and its valid flag in order
// assumes the clock of the serializer and one strobe per chip
`timescale 1ns/10ps
module chip_sink (
    input wire logic clk,
    input wire logic tx_chip,
    input wire logic tx_chip_strobe,
    input wire logic tx_chip_data
);
    logic chips [0:2047];
    logic flags [0:2047];
    int count = 0;

    always @(posedge clk) begin
        if (tx_chip_strobe === 1'b1) begin
            chips[count] <= tx_chip;
            flags[count] <= tx_chip_data;
            count <= count + 1;
        end
    end
endmodule

/* File: verif/dsss_tx_serializer_bench.sv */
// self-checking bench of the transmit serializer through its register port
// assumes the chip_sink model and the package constants of the design
`timescale 1ns/10ps
`define CHK(got, exp) begin \
    comparisons++; \
    if ((got) !== (exp)) begin \
        fail_count++; \
        $display("ERROR at %0t: got %h expected %h", $time, (got), (exp)); \
    end \
end

module dsss_tx_serializer_bench;
    import dsss_tx_pkg::*;
    logic clk;
    logic rst;
    logic reg_wr;
    logic reg_rd;
    logic [5:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic tx_chip;
    logic tx_chip_strobe;
    logic tx_chip_data;
    logic tx_busy;
    logic [63:0] seq;
    int fail_count = 0;
    int comparisons = 0;

    dsss_tx_serializer #(.ADDR_W(6)) dsss_tx_serializer_inst (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_chip(tx_chip),
        .tx_chip_strobe(tx_chip_strobe), .tx_chip_data(tx_chip_data), .tx_busy(tx_busy)
    );
    chip_sink chip_sink_inst (
        .clk(clk), .tx_chip(tx_chip), .tx_chip_strobe(tx_chip_strobe),
        .tx_chip_data(tx_chip_data)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
    endtask

    task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
        @(negedge clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge clk);
        reg_rd = 1'b0;
        `CHK(reg_rdata, exp)
    endtask

    task automatic wait_idle;
        int n;
        n = 0;
        while (tx_busy !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        n = 0;
        while (tx_busy !== 1'b0 && n < 3000) begin
            @(negedge clk);
            n++;
        end
        `CHK(tx_busy, 1'b0)
        repeat (3) @(negedge clk);
    endtask

    // byte goes out once transmit is switched on; chips checked against the sequence
    task automatic send(input logic [1:0] mode, input logic [7:0] data,
                        input logic [7:0] mask, input logic [7:0] st);
        int base;
        int bits;
        int per;
        int off;
        int k;
        base = chip_sink_inst.count;
        bits = 0;
        for (int i = 0; i < 8; i++) begin
            if (mask[i]) bits = i + 1;
        end
        per = (mode == 2'h0) ? 64 : 32;
        wr(ADDR_SPREAD_MODE, {6'h00, mode});
        wr(ADDR_TX_MASK, mask);
        wr(ADDR_TX_BYTE, data);
        wr(ADDR_CONTROL, 8'h80);
        wait_idle();
        `CHK(chip_sink_inst.count - base, bits * per)
        k = base;
        for (int t = 0; t < bits; t++) begin
            off = (mode == 2'h2 || (mode == 2'h3 && t[0])) ? 32 : 0;
            for (int j = 0; j < per; j++) begin
                `CHK(chip_sink_inst.chips[k], seq[off + j] ~^ data[t])
                `CHK(chip_sink_inst.flags[k], mask[t])
                k++;
            end
        end
        rd_chk(ADDR_TX_STATUS, st);
        rd_chk(ADDR_TX_STATUS, 8'h01);
    endtask

    task automatic wrap_up;
        $display("comparisons=%0d fail_count=%0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge clk);
        fail_count++;
        wrap_up();
    end

    initial begin
        rst = 1'b1;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 6'h00;
        reg_wdata = 8'h00;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        rd_chk(ADDR_TX_BYTE, TX_BYTE_RESET);
        rd_chk(ADDR_TX_MASK, TX_MASK_RESET);
        rd_chk(ADDR_TX_STATUS, 8'h00);
        for (int i = 0; i < 8; i++) begin
            rd_chk(ADDR_SEQ_LO + 6'(i), SEQ_RESET[8*i +: 8]);
        end
        rd_chk(6'h19, 8'h00);
        // balanced test code for the stream
        seq = 64'h0f3c_5a96_c3a5_e11e;
        for (int i = 0; i < 8; i++) begin
            wr(ADDR_SEQ_LO + 6'(i), seq[8*i +: 8]);
        end
        for (int i = 0; i < 8; i++) begin
            rd_chk(ADDR_SEQ_LO + 6'(i), seq[8*i +: 8]);
        end
        // alternating halves first, so alternation starts on the low half
        send(2'h3, 8'h05, 8'h07, 8'h0B);
        send(2'h1, 8'hC6, 8'hFF, 8'h0B);
        send(2'h2, 8'h39, 8'h0F, 8'h0B);
        send(2'h0, 8'h00, 8'h10, 8'h0B);
        wr(ADDR_TX_STATUS, 8'hFF);
        rd_chk(ADDR_TX_STATUS, 8'h01);
        wr(ADDR_CONTROL, 8'h40);
        rd_chk(ADDR_CONTROL, 8'h40);
        rd_chk(ADDR_TX_STATUS, 8'h00);
        // second byte while the first is still pending
        wr(ADDR_TX_BYTE, 8'h00);
        send(2'h0, 8'hA5, 8'h0F, 8'h0F);
        wr(ADDR_CONTROL, 8'h00);
        rd_chk(ADDR_TX_STATUS, 8'h00);
        wr(ADDR_CONTROL, 8'h80);
        rd_chk(ADDR_TX_STATUS, 8'h01);
        // second byte written while the first is on the air clears empty
        wr(ADDR_TX_MASK, 8'h01);
        wr(ADDR_TX_BYTE, 8'h5A);
        wr(ADDR_TX_BYTE, 8'hC3);
        rd_chk(ADDR_TX_STATUS, 8'h00);
        // busy dips for one cycle between the two bytes
        wait_idle();
        wait_idle();
        rd_chk(ADDR_TX_STATUS, 8'h0B);
        wrap_up();
    end
endmodule
